// [design/cat_alarm_trim.sv]
/*
  Alarm compare, repeat counter, alarm pulse and per-minute trim of a BCD clock-calendar.
  Assumes the calendar counter runs beside it on ref_clk and gives one-cycle tick pulses,
  and that the register master follows the plain strobe protocol with read data next cycle.

// Behaviour
// - alarm month: tens bit 12, ones bits 11 to 8
// - alarm day: tens bits 5:4, ones bits 3:0
// - alarm weekday digit in bits 10:8, values 0 to 6
// - alarm hour: tens bits 5:4, ones bits 3:0
// - alarm minute: tens bits 14:12, ones bits 11:8
// - alarm second: tens bits 6:4, ones bits 3:0
// - unimplemented alarm value bits read zero and ignore writes
// - month/day and weekday/hour writes need write_unlock set
// - signed trim byte times four applied to timer once a minute
// - one trim step is four pulses, negative removes pulses
// - arm bit 15; each alarm decrements count; alarm at zero disarms
// - endless repeat wraps count zero to FFh and stays armed
// - eight-bit count; FFh gives 255 more alarms, zero gives one
// - selector bits 13:10 choose interval half-second up to year
// - each interval code adds the listed digits to the compare
// - February 29 yearly alarm fires only in leap years
// - interrupt request on every alarm event including repeats
// - alarm pulse output toggles each alarm, half alarm rate
// - selector codes 1010 to 1111 are reserved
// - window pointer selects register, decrements on high access to 00
*/
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "cat_map.svh"

module cat_alarm_trim
  import cat_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // clock-calendar counter side
  input wire cat_time_s cal_time,
  input wire logic half_sec_tick,
  input wire logic second_start,
  input wire logic minute_tick,
  input wire logic rollover_window_flag,
  // results
  output logic alarm_irq,
  output logic alarm_pulse,
  output cat_trim_s trim_out
);

  // alarm_cfg_reg state
  logic alarm_arm;
  logic chime;
  logic [3:0] match_interval_sel;
  logic [1:0] alarm_window_ptr;
  logic [7:0] repeat_count;
  // config_trim_reg state
  logic write_unlock;
  logic [7:0] trim_value;
  // alarm compare values
  logic [15:0] alarm_month_day;
  logic [15:0] alarm_weekday_hour;
  logic [15:0] alarm_minute_second;

  // decoded strobes
  logic wr_cfg;
  logic wr_trim;
  logic wr_lo;
  logic wr_hi;
  logic rd_hi;
  logic wr_md;
  logic wr_wh;
  logic wr_ms;
  logic alarm_event;
  logic digits_match;

  // implemented-bit mask of the register a window pointer selects
  function automatic logic [15:0] ptr_mask(input logic [1:0] ptr);
    logic [15:0] m;
    m = 16'h0000;
    unique case (ptr)
      `CAT_PTR_MS: m = `CAT_MASK_MS;
      `CAT_PTR_WH: m = `CAT_MASK_WH;
      `CAT_PTR_MD: m = `CAT_MASK_MD;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  // pointer value after an upper-half access; it sticks at zero
  function automatic logic [1:0] ptr_step(input logic [1:0] ptr);
    return (ptr == `CAT_PTR_MS) ? `CAT_PTR_MS : ptr - 2'h1;
  endfunction

  // merge a byte lane into a register, keeping only implemented bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [15:0] lanes,
                                             input logic [15:0] impl);
    return ((old_val & ~lanes) | (new_val & lanes)) & impl;
  endfunction

  // register decode
  always_comb begin
    wr_cfg = reg_wr && (reg_addr == `CAT_OFS_ALARM_CFG);
    wr_trim = reg_wr && (reg_addr == `CAT_OFS_CFG_TRIM);
    wr_lo = reg_wr && (reg_addr == `CAT_OFS_WIN_LO);
    wr_hi = reg_wr && (reg_addr == `CAT_OFS_WIN_HI);
    rd_hi = reg_rd && (reg_addr == `CAT_OFS_WIN_HI);
    wr_md = reg_wr && (reg_addr == `CAT_OFS_ALARM_MD) && write_unlock;
    wr_wh = reg_wr && (reg_addr == `CAT_OFS_ALARM_WH) && write_unlock;
    wr_ms = reg_wr && (reg_addr == `CAT_OFS_ALARM_MS);
  end

  // masked digit comparator; each wider interval adds digits on top, except that month and year leave out the weekday digit
  always_comb begin
    logic sec_one;
    logic sec_ten;
    logic min_one;
    logic min_ten;
    logic hour_eq;
    logic weekday_digit_eq;
    logic day_eq;
    logic mon_eq;
    sec_one = cal_time.second_ones == alarm_minute_second[3:0];
    sec_ten = cal_time.second_tens == alarm_minute_second[6:4];
    min_one = cal_time.minute_ones == alarm_minute_second[11:8];
    min_ten = cal_time.minute_tens == alarm_minute_second[14:12];
    hour_eq = (cal_time.hour_tens == alarm_weekday_hour[5:4]) &&
              (cal_time.hour_ones == alarm_weekday_hour[3:0]);
    weekday_digit_eq = cal_time.weekday_digit == alarm_weekday_hour[10:8];
    day_eq = (cal_time.day_tens == alarm_month_day[5:4]) &&
             (cal_time.day_ones == alarm_month_day[3:0]);
    mon_eq = (cal_time.month_tens == alarm_month_day[12]) &&
             (cal_time.month_ones == alarm_month_day[11:8]);
    // a Feb 29 date only ever meets a calendar that holds that date
    unique case (match_interval_sel)
      CAT_IV_HALF_SEC: digits_match = 1'b1;
      CAT_IV_SEC: digits_match = second_start;
      CAT_IV_10_SEC: digits_match = second_start && sec_one;
      CAT_IV_MIN: digits_match = second_start && sec_one && sec_ten;
      CAT_IV_10_MIN: digits_match = second_start && sec_one && sec_ten && min_one;
      CAT_IV_HOUR: digits_match = second_start && sec_one && sec_ten && min_one && min_ten;
      CAT_IV_DAY: digits_match = second_start && sec_one && sec_ten && min_one &&
                                 min_ten && hour_eq;
      CAT_IV_WEEK: digits_match = second_start && sec_one && sec_ten && min_one &&
                                  min_ten && hour_eq && weekday_digit_eq;
      CAT_IV_MONTH: digits_match = second_start && sec_one && sec_ten && min_one &&
                                   min_ten && hour_eq && day_eq;
      CAT_IV_YEAR: digits_match = second_start && sec_one && sec_ten && min_one &&
                                  min_ten && hour_eq && day_eq && mon_eq;
      // reserved codes never match, so a stray setting stays silent
      default: digits_match = 1'b0;
    endcase
  end

  // only the tick cycle is evaluated, so one alarm per matching tick
  assign alarm_event = alarm_arm && half_sec_tick && digits_match;

  // arm bit: hardware disarm beats a software write in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_arm <= 1'b0;
    end else if (alarm_event) begin
      if ((repeat_count == 8'h00) && !chime) begin
        alarm_arm <= 1'b0;
      end
    end else if (wr_cfg) begin
      alarm_arm <= reg_wdata[`CAT_CFG_ARM_BIT];
    end
  end

  // repeat counter; wraps to FFh only while chime keeps it going
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      repeat_count <= `CAT_RST_RPT;
    end else if (alarm_event) begin
      if ((repeat_count != 8'h00) || chime) begin
        repeat_count <= repeat_count - 8'h01;
      end
    end else if (wr_cfg) begin
      repeat_count <= reg_wdata[`CAT_CFG_RPT_HI:`CAT_CFG_RPT_LO];
    end
  end

  // chime and interval selector are plain software bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chime <= `CAT_RST_CHIME;
      match_interval_sel <= `CAT_RST_SEL;
    end else if (wr_cfg) begin
      chime <= reg_wdata[`CAT_CFG_CHIME_BIT];
      match_interval_sel <= reg_wdata[`CAT_CFG_MASK_HI:`CAT_CFG_MASK_LO];
    end
  end

  // window pointer: loaded by config write, stepped by upper-half access
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_window_ptr <= `CAT_RST_PTR;
    end else if (wr_cfg) begin
      alarm_window_ptr <= reg_wdata[`CAT_CFG_PTR_HI:`CAT_CFG_PTR_LO];
    end else if (wr_hi || rd_hi) begin
      alarm_window_ptr <= ptr_step(alarm_window_ptr);
    end
  end

  // unlock bit and trim byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_unlock <= 1'b0;
      trim_value <= `CAT_RST_TRIM;
    end else if (wr_trim) begin
      write_unlock <= reg_wdata[`CAT_TRIM_UNLOCK_BIT];
      // no guard on timing; writing at a safe moment is left to software
      trim_value <= reg_wdata[`CAT_TRIM_HI:`CAT_TRIM_LO];
    end
  end

  // month/day compare value, direct or through the window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_month_day <= `CAT_RST_VALUE;
    end else if (wr_md) begin
      alarm_month_day <= reg_wdata & `CAT_MASK_MD;
    end else if (write_unlock && (alarm_window_ptr == `CAT_PTR_MD) && (wr_lo || wr_hi)) begin
      alarm_month_day <= lane_merge(alarm_month_day, reg_wdata,
                                    wr_hi ? 16'hFF00 : 16'h00FF, `CAT_MASK_MD);
    end
  end

  // weekday/hour compare value, direct or through the window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_weekday_hour <= `CAT_RST_VALUE;
    end else if (wr_wh) begin
      alarm_weekday_hour <= reg_wdata & `CAT_MASK_WH;
    end else if (write_unlock && (alarm_window_ptr == `CAT_PTR_WH) && (wr_lo || wr_hi)) begin
      alarm_weekday_hour <= lane_merge(alarm_weekday_hour, reg_wdata,
                                       wr_hi ? 16'hFF00 : 16'h00FF, `CAT_MASK_WH);
    end
  end

  // minute/second compare value needs no unlock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_minute_second <= `CAT_RST_VALUE;
    end else if (wr_ms) begin
      alarm_minute_second <= reg_wdata & `CAT_MASK_MS;
    end else if ((alarm_window_ptr == `CAT_PTR_MS) && (wr_lo || wr_hi)) begin
      alarm_minute_second <= lane_merge(alarm_minute_second, reg_wdata,
                                        wr_hi ? 16'hFF00 : 16'h00FF, `CAT_MASK_MS);
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CAT_OFS_ALARM_CFG: reg_rdata <= {alarm_arm, chime, match_interval_sel,
                                          alarm_window_ptr, repeat_count};
        `CAT_OFS_CFG_TRIM: reg_rdata <= {2'b00, write_unlock, rollover_window_flag,
                                         4'h0, trim_value};
        `CAT_OFS_WIN_LO, `CAT_OFS_WIN_HI: begin
          // pointer code 11 selects nothing and reads as zero
          unique case (alarm_window_ptr)
            `CAT_PTR_MS: reg_rdata <= alarm_minute_second & ptr_mask(alarm_window_ptr) &
                                      ((reg_addr == `CAT_OFS_WIN_HI) ? 16'hFF00 : 16'h00FF);
            `CAT_PTR_WH: reg_rdata <= alarm_weekday_hour & ptr_mask(alarm_window_ptr) &
                                      ((reg_addr == `CAT_OFS_WIN_HI) ? 16'hFF00 : 16'h00FF);
            `CAT_PTR_MD: reg_rdata <= alarm_month_day & ptr_mask(alarm_window_ptr) &
                                      ((reg_addr == `CAT_OFS_WIN_HI) ? 16'hFF00 : 16'h00FF);
            default: reg_rdata <= 16'h0000;
          endcase
        end
        `CAT_OFS_ALARM_MD: reg_rdata <= alarm_month_day;
        `CAT_OFS_ALARM_WH: reg_rdata <= alarm_weekday_hour;
        `CAT_OFS_ALARM_MS: reg_rdata <= alarm_minute_second;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // interrupt request and half-rate alarm pulse, both from flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_irq <= 1'b0;
      alarm_pulse <= 1'b0;
    end else begin
      alarm_irq <= alarm_event;
      if (alarm_event) begin
        alarm_pulse <= ~alarm_pulse;
      end
    end
  end

  // trim: one correction of four pulses per step at each minute tick
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_out <= '0;
    end else begin
      trim_out.apply <= minute_tick;
      if (minute_tick) begin
        // times four; ten bits hold the signed product exactly
        trim_out.pulses <= {trim_value, 2'b00};
      end
    end
  end

endmodule

// [design/cat_map.svh]
/*
  Register offsets, field positions and reset values of the calendar alarm and trim block.
  Assumes it is included by its bare name after cat_pkg is compiled.
*/
`ifndef CAT_MAP_SVH
`define CAT_MAP_SVH

// register word offsets on the plain register port
`define CAT_OFS_ALARM_CFG 3'h0
`define CAT_OFS_CFG_TRIM 3'h1
`define CAT_OFS_WIN_LO 3'h2
`define CAT_OFS_WIN_HI 3'h3
`define CAT_OFS_ALARM_MD 3'h4
`define CAT_OFS_ALARM_WH 3'h5
`define CAT_OFS_ALARM_MS 3'h6

// alarm_cfg_reg fields
`define CAT_CFG_ARM_BIT 15
`define CAT_CFG_CHIME_BIT 14
`define CAT_CFG_MASK_HI 13
`define CAT_CFG_MASK_LO 10
`define CAT_CFG_PTR_HI 9
`define CAT_CFG_PTR_LO 8
`define CAT_CFG_RPT_HI 7
`define CAT_CFG_RPT_LO 0

// config_trim_reg fields
`define CAT_TRIM_UNLOCK_BIT 13
`define CAT_TRIM_ROLL_BIT 12
`define CAT_TRIM_HI 7
`define CAT_TRIM_LO 0

// implemented bits of the alarm value registers
`define CAT_MASK_MD 16'h1F3F
`define CAT_MASK_WH 16'h073F
`define CAT_MASK_MS 16'h7F7F

// window pointer codes
`define CAT_PTR_MS 2'h0
`define CAT_PTR_WH 2'h1
`define CAT_PTR_MD 2'h2
`define CAT_PTR_NONE 2'h3

// reset values
`define CAT_RST_ALARM_CFG 16'h0000
`define CAT_RST_VALUE 16'h0000
`define CAT_RST_TRIM 8'h00
`define CAT_RST_RPT 8'h00
`define CAT_RST_CHIME 1'b0
`define CAT_RST_SEL 4'h0
`define CAT_RST_PTR 2'h0

`endif

// [design/cat_pkg.sv]
/*
  Types shared by the calendar alarm and trim block and its bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cat_pkg;

  // alarm interval selector codes
  typedef enum logic [3:0] {
    CAT_IV_HALF_SEC = 4'h0,
    CAT_IV_SEC = 4'h1,
    CAT_IV_10_SEC = 4'h2,
    CAT_IV_MIN = 4'h3,
    CAT_IV_10_MIN = 4'h4,
    CAT_IV_HOUR = 4'h5,
    CAT_IV_DAY = 4'h6,
    CAT_IV_WEEK = 4'h7,
    CAT_IV_MONTH = 4'h8,
    CAT_IV_YEAR = 4'h9
  } cat_interval_e;

  // current clock-calendar value, BCD digits
  typedef struct packed {
    logic month_tens;
    logic [3:0] month_ones;
    logic [1:0] day_tens;
    logic [3:0] day_ones;
    logic [2:0] weekday_digit;
    logic [1:0] hour_tens;
    logic [3:0] hour_ones;
    logic [2:0] minute_tens;
    logic [3:0] minute_ones;
    logic [2:0] second_tens;
    logic [3:0] second_ones;
  } cat_time_s;

  // trim correction handed to the timer counter
  typedef struct packed {
    logic apply;
    logic [9:0] pulses;
  } cat_trim_s;

endpackage

// [testbench/cat_alarm_trim_sva.sv]
/*
  Checker for the alarm and trim block; it watches only the top ports.
  Assumes one clock domain and a bind from the testbench top file.
*/
`timescale 1ns/100ps
`include "cat_map.svh"
module cat_alarm_trim_sva
  import cat_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // calendar side and results
  input wire logic half_sec_tick,
  input wire logic minute_tick,
  input wire logic alarm_irq,
  input wire logic alarm_pulse,
  input wire cat_trim_s trim_out
);
  logic [7:0] trim_seen;

  // shadow of the trim byte so the correction can be tied to what software wrote
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_seen <= 8'h00;
    end else if (reg_wr && reg_addr == `CAT_OFS_CFG_TRIM) begin
      trim_seen <= reg_wdata[7:0];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // an alarm is the irq cycle right after a half-second tick
  sequence alarm_fire_s;
    $past(half_sec_tick) && alarm_irq;
  endsequence

  irq_src_a: assert property (alarm_irq |-> $past(half_sec_tick))
    else $error("alarm irq without a preceding tick");
  irq_single_a: assert property (alarm_fire_s |=> !alarm_irq)
    else $error("alarm irq longer than one cycle");
  pulse_half_a: assert property ((alarm_pulse != $past(alarm_pulse)) == alarm_irq)
    else $error("alarm pulse not toggling with the alarm");
  apply_minute_a: assert property (trim_out.apply == $past(minute_tick))
    else $error("trim apply not one cycle after minute tick");
  trim_value_a: assert property (trim_out.apply |->
    trim_out.pulses == {trim_seen, 2'b00})
    else $error("trim pulses not four times the trim byte");
  pulses_held_a: assert property (!trim_out.apply |-> $stable(trim_out.pulses))
    else $error("trim pulses changed between minutes");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the read answer cycle");
  ms_bits_a: assert property ($past(reg_rd && reg_addr == `CAT_OFS_ALARM_MS) |->
    (reg_rdata & 16'h8080) == 16'h0000)
    else $error("minute second unused bits not zero");
  md_bits_a: assert property ($past(reg_rd && reg_addr == `CAT_OFS_ALARM_MD) |->
    (reg_rdata & 16'hE0C0) == 16'h0000)
    else $error("month day unused bits not zero");
  wh_bits_a: assert property ($past(reg_rd && reg_addr == `CAT_OFS_ALARM_WH) |->
    (reg_rdata & 16'hF8C0) == 16'h0000)
    else $error("weekday hour unused bits not zero");
endmodule

// [testbench/testbench.sv]
/*
  Self-checking bench for the alarm and trim block.
  Assumes package, map header, design and checker are compiled before it.
*/
`timescale 1ns/100ps
`include "cat_map.svh"
module testbench;
  import cat_pkg::*;
  logic ref_clk, arst_n, reg_wr, reg_rd, half_sec_tick, second_start, minute_tick;
  logic rollover_window_flag, alarm_irq, alarm_pulse;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  cat_time_s cal_time;
  cat_trim_s trim_out;
  int err_total, checks_done, cyc;

  cat_alarm_trim u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cal_time(cal_time), .half_sec_tick(half_sec_tick), .second_start(second_start),
    .minute_tick(minute_tick), .rollover_window_flag(rollover_window_flag),
    .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse), .trim_out(trim_out));

  // compare and count; x never passes
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic tick(input logic ss, output logic fired);
    @(posedge ref_clk);
    half_sec_tick <= 1'b1;
    second_start <= ss;
    @(posedge ref_clk);
    half_sec_tick <= 1'b0;
    second_start <= 1'b0;
    #1 fired = alarm_irq;
  endtask

  // arm one alarm with selector c, disturb one calendar digit f, expect e
  task automatic try_sel(input logic [3:0] c, input logic ss, input int f, input logic e);
    logic fired;
    cat_time_s t;
    t = '0;
    case (f)
      1: t.second_ones = 4'h1;
      2: t.second_tens = 3'h1;
      3: t.minute_ones = 4'h1;
      4: t.minute_tens = 3'h1;
      5: t.hour_ones = 4'h1;
      6: t.hour_tens = 2'h1;
      7: t.weekday_digit = 3'h1;
      8: t.day_ones = 4'h1;
      9: t.month_ones = 4'h1;
      default: t = '0;
    endcase
    wr(`CAT_OFS_ALARM_CFG, {2'b10, c, 10'h000});
    cal_time <= t;
    tick(ss, fired);
    chk(16'(fired), 16'(e));
    wr(`CAT_OFS_ALARM_CFG, 16'h0000);
  endtask

  task automatic test_regs();
    logic [15:0] d;
    rd(`CAT_OFS_ALARM_CFG, d);
    chk(d, 16'h0000);
    wr(`CAT_OFS_ALARM_MS, 16'hFFFF);
    rd(`CAT_OFS_ALARM_MS, d);
    chk(d, 16'h7F7F);
    wr(`CAT_OFS_ALARM_MD, 16'hFFFF);
    rd(`CAT_OFS_ALARM_MD, d);
    chk(d, 16'h0000);
    wr(`CAT_OFS_CFG_TRIM, 16'h2000);
    rollover_window_flag <= 1'b1;
    rd(`CAT_OFS_CFG_TRIM, d);
    chk(d, 16'h3000);
    rollover_window_flag <= 1'b0;
    wr(`CAT_OFS_ALARM_MD, 16'hFFFF);
    rd(`CAT_OFS_ALARM_MD, d);
    chk(d, 16'h1F3F);
    wr(`CAT_OFS_ALARM_WH, 16'hFFFF);
    rd(`CAT_OFS_ALARM_WH, d);
    chk(d, 16'h073F);
    rd(3'h7, d);
    chk(d, 16'h0000);
    wr(`CAT_OFS_ALARM_MS, 16'h0000);
    wr(`CAT_OFS_ALARM_MD, 16'h0000);
    wr(`CAT_OFS_ALARM_WH, 16'h0000);
    // window pointer steps down on high-half access and stops at zero
    wr(`CAT_OFS_ALARM_CFG, 16'h0200);
    rd(`CAT_OFS_WIN_HI, d);
    rd(`CAT_OFS_ALARM_CFG, d);
    chk(d, 16'h0100);
    wr(`CAT_OFS_WIN_HI, 16'h0000);
    rd(`CAT_OFS_WIN_HI, d);
    rd(`CAT_OFS_ALARM_CFG, d);
    chk(d, 16'h0000);
    $display("test regs done");
  endtask

  task automatic test_trim();
    logic [7:0] tv [3] = '{8'hFF, 8'h7F, 8'h80};
    logic [9:0] pv [3] = '{10'h3FC, 10'h1FC, 10'h200};
    for (int i = 0; i < 3; i++) begin
      wr(`CAT_OFS_CFG_TRIM, {8'h20, tv[i]});
      @(posedge ref_clk);
      minute_tick <= 1'b1;
      @(posedge ref_clk);
      minute_tick <= 1'b0;
      #1 chk(16'(trim_out.apply), 16'h0001);
      chk(16'(trim_out.pulses), 16'(pv[i]));
    end
    $display("test trim done");
  endtask

  task automatic test_repeat();
    logic f, p;
    logic [15:0] d;
    // count of one gives two alarms, then the arm bit drops
    wr(`CAT_OFS_ALARM_CFG, 16'h8001);
    for (int i = 0; i < 3; i++) begin
      p = alarm_pulse;
      tick(1'b0, f);
      chk(16'(f), 16'(i < 2));
      chk(16'(alarm_pulse), 16'(p ^ f));
    end
    rd(`CAT_OFS_ALARM_CFG, d);
    chk(d, 16'h0000);
    wr(`CAT_OFS_ALARM_CFG, 16'hC000);
    tick(1'b0, f);
    rd(`CAT_OFS_ALARM_CFG, d);
    chk(d, 16'hC0FF);
    tick(1'b0, f);
    chk(16'(f), 16'h0001);
    wr(`CAT_OFS_ALARM_CFG, 16'h0000);
    $display("test repeat done");
  endtask

  task automatic test_select();
    for (int c = 1; c < 10; c++) begin
      try_sel(4'(c), 1'b0, 0, 1'b0);
      try_sel(4'(c), 1'b1, 0, 1'b1);
    end
    try_sel(4'h0, 1'b0, 0, 1'b1);
    try_sel(4'hA, 1'b1, 0, 1'b0);
    try_sel(4'hF, 1'b1, 0, 1'b0);
    try_sel(4'h2, 1'b1, 1, 1'b0); try_sel(4'h2, 1'b1, 2, 1'b1);
    try_sel(4'h3, 1'b1, 2, 1'b0); try_sel(4'h4, 1'b1, 4, 1'b1);
    try_sel(4'h4, 1'b1, 3, 1'b0); try_sel(4'h5, 1'b1, 4, 1'b0);
    try_sel(4'h5, 1'b1, 6, 1'b1); try_sel(4'h6, 1'b1, 5, 1'b0);
    try_sel(4'h6, 1'b1, 7, 1'b1); try_sel(4'h7, 1'b1, 7, 1'b0);
    try_sel(4'h7, 1'b1, 8, 1'b1); try_sel(4'h8, 1'b1, 8, 1'b0);
    try_sel(4'h8, 1'b1, 9, 1'b1); try_sel(4'h9, 1'b1, 9, 1'b0);
    $display("test select done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, half_sec_tick, second_start, minute_tick} = '0;
    rollover_window_flag = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    cal_time = '0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    test_regs();
    test_trim();
    test_repeat();
    test_select();
    test_done();
  end
endmodule

bind cat_alarm_trim cat_alarm_trim_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .half_sec_tick(half_sec_tick),
  .minute_tick(minute_tick), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse),
  .trim_out(trim_out));
